/* File: shared/flash_map_pkg.sv */
// shared constants for the flash page map and protection decode
package flash_map_pkg;

  // cpu windows onto the array, three 16 Kbyte spans
  localparam logic [15:0] WIN_LO_START = 16'h4000;
  localparam logic [15:0] WIN_LO_END = 16'h7fff;
  localparam logic [15:0] WIN_MID_START = 16'h8000;
  localparam logic [15:0] WIN_MID_END = 16'hbfff;
  localparam logic [15:0] WIN_HI_START = 16'hc000;
  localparam logic [15:0] WIN_HI_END = 16'hffff;

  // page numbers of the two fixed pages
  localparam logic [7:0] PAGE_BOTTOM = 8'h3e;
  localparam logic [7:0] PAGE_TOP = 8'h3f;
  localparam int PAGE_MIN_W = 6;

  // array geometry
  localparam int PAGE_OFF_W = 14;
  localparam int ARRAY_OFF_W = 15;
  localparam logic [15:0] ARRAY_BYTES = 16'h8000;
  localparam int ROW_LSB = 6;
  localparam int ROW_W = 9;
  localparam int SECTOR_LSB = 9;
  localparam int SECTOR_W = 6;

  // configuration field, as cpu addresses in the top fixed page
  localparam logic [15:0] KEY_FIRST_ADDR = 16'hff00;
  localparam logic [15:0] KEY_LAST_ADDR = 16'hff07;
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hff0d;
  localparam logic [15:0] SEC_BYTE_ADDR = 16'hff0f;
  localparam int KEY_IDX_W = 3;

  // protection byte field positions
  localparam int PROT_OPEN_BIT = 7;
  localparam int PROT_HI_DIS_BIT = 5;
  localparam int PROT_HI_SIZE_LSB = 3;
  localparam int PROT_LO_DIS_BIT = 2;
  localparam int PROT_LO_SIZE_LSB = 0;
  localparam int PROT_SIZE_W = 2;

  // smallest region sizes, doubled per size code step
  localparam logic [15:0] HI_BASE_SIZE = 16'h0800;
  localparam logic [15:0] LO_BASE_SIZE = 16'h0400;

  // control and status register block
  localparam int REG_COUNT = 16;
  localparam int REG_IDX_W = 4;
  localparam logic [15:0] REG_BASE_DEFAULT = 16'h0100;

  // value of every decode output after reset
  localparam logic RESET_FLAG = 1'b0;

endpackage

/* File: shared/prot_check_if.sv */
// carrier between the address decoder and the region evaluator
`timescale 1ns/10ps
interface prot_check_if;
  logic [flash_map_pkg::ARRAY_OFF_W-1:0] array_offset;
  logic [7:0] prot_byte;
  logic in_low;
  logic in_high;
  logic in_other;
  logic protect_hit;
  logic prot_global;

  modport decoder (
    output array_offset,
    output prot_byte,
    input in_low,
    input in_high,
    input in_other,
    input protect_hit,
    input prot_global
  );

  modport evaluator (
    input array_offset,
    input prot_byte,
    output in_low,
    output in_high,
    output in_other,
    output protect_hit,
    output prot_global
  );
endinterface

/* File: src/flash_page_map_protect_decode.sv */
// cpu address to flash array decode with protection regions
`timescale 1ns/10ps
// Notes on behaviour
// - cpu addresses 0x4000 to 0xffff reach the array as three 16K windows
// - middle window 0x8000-0xbfff selects the page named by the page register
// - page 0x3e or 0x3f makes the middle window alias a fixed page
// - array bytes 0x7f00 to 0x7f07 (cpu 0xff00 to 0xff07) form the backdoor key
// - protection byte sits at 0xff0d, security byte at 0xff0f
// - protection control can lock the whole array against program and erase
// - high region grows down from array end, 2K up to 16K in size
// - low region grows up from array start, 1K up to 8K in size
// - remaining addresses form a third region with its own protection
// - high region covers the vector space so boot code can be guarded
// - sixteen control and status registers decode at base plus 0x0 to 0xf
// - no off-chip pins; everything goes over the internal bus
// - array is 512 rows of 64 bytes, erase sector of 512 bytes
module flash_page_map_protect_decode #(
  parameter int PAGE_W = 8,
  parameter logic [15:0] REG_BASE = flash_map_pkg::REG_BASE_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [15:0] bus_addr,
  input wire logic [PAGE_W-1:0] core_page_select,
  input wire logic [7:0] flash_protect_control,
  output logic array_hit,
  output logic [flash_map_pkg::ARRAY_OFF_W-1:0] array_offset,
  output logic [flash_map_pkg::ROW_W-1:0] array_row,
  output logic [flash_map_pkg::SECTOR_W-1:0] array_sector,
  output logic fixed_alias,
  output logic key_hit,
  output logic [flash_map_pkg::KEY_IDX_W-1:0] key_index,
  output logic prot_byte_hit,
  output logic sec_byte_hit,
  output logic in_low_region,
  output logic in_high_region,
  output logic in_other_region,
  output logic prot_global,
  output logic prog_blocked,
  output logic reg_hit,
  output logic [flash_map_pkg::REG_IDX_W-1:0] reg_index
);

  localparam logic [PAGE_W-1:0] TOP_PAGE =
    PAGE_W'(flash_map_pkg::PAGE_TOP);
  localparam logic [PAGE_W-1:0] BOTTOM_PAGE =
    PAGE_W'(flash_map_pkg::PAGE_BOTTOM);
  localparam logic [15:0] KEY_FIRST_OFF =
    {2'b01, flash_map_pkg::KEY_FIRST_ADDR[13:0]};
  localparam logic [15:0] KEY_LAST_OFF =
    {2'b01, flash_map_pkg::KEY_LAST_ADDR[13:0]};
  localparam logic [15:0] PROT_BYTE_OFF =
    {2'b01, flash_map_pkg::PROT_BYTE_ADDR[13:0]};
  localparam logic [15:0] SEC_BYTE_OFF =
    {2'b01, flash_map_pkg::SEC_BYTE_ADDR[13:0]};
  localparam logic [15:0] REG_LAST =
    REG_BASE + 16'(flash_map_pkg::REG_COUNT - 1);

  // the page register must be wide enough to name the fixed pages
  if (PAGE_W < flash_map_pkg::PAGE_MIN_W) begin : g_page_w_check
    $error("PAGE_W too narrow for the fixed page numbers");
  end
  // the register block must sit on a 16 byte boundary
  if (REG_BASE[flash_map_pkg::REG_IDX_W-1:0] != '0) begin : g_base_check
    $error("REG_BASE must be aligned to the register block size");
  end

  // inclusive range test, shared by window, field and register decode
  function automatic logic in_span(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational address decode

  prot_check_if chk ();

  protect_region_eval u_region (
    .chk(chk.evaluator)
  );

  logic in_lo_win;
  logic in_mid_win;
  logic in_hi_win;
  logic [PAGE_W-1:0] page_sel;
  logic page_in_array;
  logic hit_c;
  logic [15:0] off_ext;

  // the fixed windows ignore the page register; only the middle follows it
  always_comb begin
    in_lo_win = in_span(bus_addr, flash_map_pkg::WIN_LO_START,
                        flash_map_pkg::WIN_LO_END);
    in_mid_win = in_span(bus_addr, flash_map_pkg::WIN_MID_START,
                         flash_map_pkg::WIN_MID_END);
    in_hi_win = in_span(bus_addr, flash_map_pkg::WIN_HI_START,
                        flash_map_pkg::WIN_HI_END);
    if (in_lo_win) begin
      page_sel = BOTTOM_PAGE;
    end else if (in_hi_win) begin
      page_sel = TOP_PAGE;
    end else begin
      page_sel = core_page_select;
    end
    // a 32K array holds only the two pages that differ in bit 0
    page_in_array = page_sel[PAGE_W-1:1] == TOP_PAGE[PAGE_W-1:1];
    hit_c = (in_lo_win || in_mid_win || in_hi_win) && page_in_array;
    chk.array_offset = {page_sel[0],
                        bus_addr[flash_map_pkg::PAGE_OFF_W-1:0]};
    chk.prot_byte = flash_protect_control;
    off_ext = {1'b0, chk.array_offset};
  end

  ////////////////////////////////////////////////////////////////////////
  // registered decode results

  logic array_hit_reg, array_hit_next;
  logic [flash_map_pkg::ARRAY_OFF_W-1:0] offset_reg, offset_next;
  logic alias_reg, alias_next;
  logic key_reg, key_next;
  logic [flash_map_pkg::KEY_IDX_W-1:0] key_idx_reg, key_idx_next;
  logic prot_hit_reg, prot_hit_next;
  logic sec_hit_reg, sec_hit_next;
  logic low_reg, low_next;
  logic high_reg, high_next;
  logic other_reg, other_next;
  logic global_reg, global_next;
  logic blocked_reg, blocked_next;
  logic reg_hit_reg, reg_hit_next;
  logic [flash_map_pkg::REG_IDX_W-1:0] reg_idx_reg, reg_idx_next;

  // every result but prot_global qualifies on a valid bus cycle; idle cycles read zero for those
  always_comb begin
    array_hit_next = bus_valid && hit_c;
    offset_next = bus_valid ? chk.array_offset : '0;
    alias_next = bus_valid && in_mid_win && page_in_array;
    key_next = array_hit_next &&
               in_span(off_ext, KEY_FIRST_OFF, KEY_LAST_OFF);
    key_idx_next = key_next ?
      chk.array_offset[flash_map_pkg::KEY_IDX_W-1:0] : '0;
    prot_hit_next = array_hit_next &&
                    in_span(off_ext, PROT_BYTE_OFF, PROT_BYTE_OFF);
    sec_hit_next = array_hit_next &&
                   in_span(off_ext, SEC_BYTE_OFF, SEC_BYTE_OFF);
    low_next = array_hit_next && chk.in_low;
    high_next = array_hit_next && chk.in_high;
    other_next = array_hit_next && chk.in_other;
    global_next = chk.prot_global;
    // only writes are checked: protection never hides array contents
    blocked_next = array_hit_next && bus_write &&
                   chk.protect_hit;
    reg_hit_next = bus_valid &&
                   in_span(bus_addr, REG_BASE, REG_LAST);
    reg_idx_next = reg_hit_next ?
      bus_addr[flash_map_pkg::REG_IDX_W-1:0] : '0;
  end

  // plain registers; outputs settle one clock after the bus cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      array_hit_reg <= flash_map_pkg::RESET_FLAG;
      offset_reg <= '0;
      alias_reg <= flash_map_pkg::RESET_FLAG;
      key_reg <= flash_map_pkg::RESET_FLAG;
      key_idx_reg <= '0;
      prot_hit_reg <= flash_map_pkg::RESET_FLAG;
      sec_hit_reg <= flash_map_pkg::RESET_FLAG;
      low_reg <= flash_map_pkg::RESET_FLAG;
      high_reg <= flash_map_pkg::RESET_FLAG;
      other_reg <= flash_map_pkg::RESET_FLAG;
      global_reg <= flash_map_pkg::RESET_FLAG;
      blocked_reg <= flash_map_pkg::RESET_FLAG;
      reg_hit_reg <= flash_map_pkg::RESET_FLAG;
      reg_idx_reg <= '0;
    end else begin
      array_hit_reg <= array_hit_next;
      offset_reg <= offset_next;
      alias_reg <= alias_next;
      key_reg <= key_next;
      key_idx_reg <= key_idx_next;
      prot_hit_reg <= prot_hit_next;
      sec_hit_reg <= sec_hit_next;
      low_reg <= low_next;
      high_reg <= high_next;
      other_reg <= other_next;
      global_reg <= global_next;
      blocked_reg <= blocked_next;
      reg_hit_reg <= reg_hit_next;
      reg_idx_reg <= reg_idx_next;
    end
  end

  // outputs; row and sector are slices of the registered offset
  assign array_hit = array_hit_reg;
  assign array_offset = offset_reg;
  assign array_row = offset_reg[flash_map_pkg::ROW_LSB +:
                                flash_map_pkg::ROW_W];
  assign array_sector = offset_reg[flash_map_pkg::SECTOR_LSB +:
                                   flash_map_pkg::SECTOR_W];
  assign fixed_alias = alias_reg;
  assign key_hit = key_reg;
  assign key_index = key_idx_reg;
  assign prot_byte_hit = prot_hit_reg;
  assign sec_byte_hit = sec_hit_reg;
  assign in_low_region = low_reg;
  assign in_high_region = high_reg;
  assign in_other_region = other_reg;
  assign prot_global = global_reg;
  assign prog_blocked = blocked_reg;
  assign reg_hit = reg_hit_reg;
  assign reg_index = reg_idx_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  logic ctl_open;
  logic ctl_hi_en;
  logic ctl_lo_en;
  assign ctl_open = flash_protect_control[flash_map_pkg::PROT_OPEN_BIT];
  assign ctl_hi_en = !flash_protect_control[flash_map_pkg::PROT_HI_DIS_BIT];
  assign ctl_lo_en = !flash_protect_control[flash_map_pkg::PROT_LO_DIS_BIT];

  property p_top_window;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && in_span(bus_addr, flash_map_pkg::WIN_HI_START,
                         flash_map_pkg::WIN_HI_END)
    |=> array_hit && array_offset == {1'b1, $past(bus_addr[13:0])};
  endproperty
  a_top_window: assert property (p_top_window)
    else $error("top window did not map onto the top page");

  property p_below_array;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && bus_addr < flash_map_pkg::WIN_LO_START |=> !array_hit;
  endproperty
  a_below_array: assert property (p_below_array)
    else $error("address below the array reported as a hit");

  property p_paged_window;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && in_mid_win
    |=> array_hit == ($past(core_page_select[PAGE_W-1:1]) ==
                      TOP_PAGE[PAGE_W-1:1]) &&
        array_offset[14] == $past(core_page_select[0]);
  endproperty
  a_paged_window: assert property (p_paged_window)
    else $error("middle window ignored the page register");

  property p_bottom_alias;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && in_mid_win && core_page_select == BOTTOM_PAGE
    |=> fixed_alias && array_offset == {1'b0, $past(bus_addr[13:0])};
  endproperty
  a_bottom_alias: assert property (p_bottom_alias)
    else $error("bottom page alias wrong in the middle window");

  property p_key_bytes;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && in_span(bus_addr, flash_map_pkg::KEY_FIRST_ADDR,
                         flash_map_pkg::KEY_LAST_ADDR)
    |=> key_hit && key_index == $past(bus_addr[2:0]) && !prot_byte_hit;
  endproperty
  a_key_bytes: assert property (p_key_bytes)
    else $error("backdoor key byte not recognised");

  property p_cfg_bytes;
    @(posedge clk) disable iff (!arst_n)
    ##1 (prot_byte_hit || sec_byte_hit)
    |-> $past(bus_addr) == (prot_byte_hit ? flash_map_pkg::PROT_BYTE_ADDR
                                           : flash_map_pkg::SEC_BYTE_ADDR)
        || $past(in_mid_win);
  endproperty
  a_cfg_bytes: assert property (p_cfg_bytes)
    else $error("configuration byte flagged at the wrong address");

  property p_global_lock;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && bus_write && hit_c && !ctl_open && !ctl_hi_en && !ctl_lo_en
    |=> prog_blocked && prot_global;
  endproperty
  a_global_lock: assert property (p_global_lock)
    else $error("global lock let a write through");

  property p_vector_guard;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && bus_write && bus_addr == flash_map_pkg::WIN_HI_END &&
    ctl_open && ctl_hi_en
    |=> prog_blocked && in_high_region && !in_other_region;
  endproperty
  a_vector_guard: assert property (p_vector_guard)
    else $error("vector space not guarded by the high region");

  property p_low_start;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && bus_addr == flash_map_pkg::WIN_LO_START
    |=> in_low_region && !in_high_region && !in_other_region;
  endproperty
  a_low_start: assert property (p_low_start)
    else $error("array start not in the low region");

  property p_read_free;
    @(posedge clk) disable iff (!arst_n)
    !bus_write |=> !prog_blocked;
  endproperty
  a_read_free: assert property (p_read_free)
    else $error("read reported as blocked");

  property p_reg_decode;
    @(posedge clk) disable iff (!arst_n)
    bus_valid && bus_addr[15:4] == REG_BASE[15:4]
    |=> reg_hit && reg_index == $past(bus_addr[3:0]);
  endproperty
  a_reg_decode: assert property (p_reg_decode)
    else $error("register slot decode wrong");

  c_key_read: cover property (@(posedge clk) disable iff (!arst_n)
    bus_valid && !bus_write ##1 key_hit);
  c_blocked: cover property (@(posedge clk) disable iff (!arst_n)
    prog_blocked ##1 !prog_blocked);
  c_alias: cover property (@(posedge clk) disable iff (!arst_n)
    fixed_alias && array_offset[14]);
  c_reg: cover property (@(posedge clk) disable iff (!arst_n)
    reg_hit ##1 reg_hit);

endmodule

/* File: src/protect_region_eval.sv */
// protection region evaluator for one array offset
`timescale 1ns/10ps
module protect_region_eval (
  prot_check_if.evaluator chk
);

  logic [15:0] offset_ext;
  logic [15:0] hi_size;
  logic [15:0] lo_size;
  logic [15:0] hi_start;
  logic hi_act;
  logic lo_act;
  logic prot_open;
  logic hi_en;
  logic lo_en;

  // region geometry from the size codes, then the enables
  always_comb begin
    offset_ext = {1'b0, chk.array_offset};
    hi_size = flash_map_pkg::HI_BASE_SIZE << chk.prot_byte[
      flash_map_pkg::PROT_HI_SIZE_LSB +: flash_map_pkg::PROT_SIZE_W];
    lo_size = flash_map_pkg::LO_BASE_SIZE << chk.prot_byte[
      flash_map_pkg::PROT_LO_SIZE_LSB +: flash_map_pkg::PROT_SIZE_W];
    // high region grows down from the array end
    hi_start = flash_map_pkg::ARRAY_BYTES - hi_size;
    chk.in_high = offset_ext >= hi_start;
    // low region grows up from the array start
    chk.in_low = offset_ext < lo_size;
    chk.in_other = !chk.in_high && !chk.in_low;
    prot_open = chk.prot_byte[flash_map_pkg::PROT_OPEN_BIT];
    hi_en = !chk.prot_byte[flash_map_pkg::PROT_HI_DIS_BIT];
    lo_en = !chk.prot_byte[flash_map_pkg::PROT_LO_DIS_BIT];
    hi_act = hi_en && chk.in_high;
    lo_act = lo_en && chk.in_low;
    // open: enabled regions protected; closed: the rest is protected
    chk.protect_hit = prot_open ? (hi_act || lo_act)
                                : !(hi_act || lo_act);
    // closed with both regions off locks the whole array
    chk.prot_global = !prot_open && !hi_en && !lo_en;
  end

endmodule

/* File: verification/cpu_core_bus_model.sv */
// behavioural cpu core bus with page register, far side of the decode
`timescale 1ns/10ps
module cpu_core_bus_model #(
  parameter int PAGE_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [PAGE_W-1:0] req_page,
  output logic bus_valid,
  output logic bus_write,
  output logic [15:0] bus_addr,
  output logic [PAGE_W-1:0] core_page_select
);
  logic [15:0] last_addr_reg;
  logic last_write_reg;

  ////////////////////////////////////////////////////////////////////////////
  // remember the last real cycle so an idle bus never repeats it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_addr_reg <= 16'h0000;
      last_write_reg <= 1'b0;
    end else if (req_valid) begin
      last_addr_reg <= req_addr;
      last_write_reg <= req_write;
    end
  end

  // released bus shows the inverse, so stale values cannot pass for decode
  always_comb begin
    bus_valid = req_valid;
    bus_write = req_valid ? req_write : ~last_write_reg;
    bus_addr = req_valid ? req_addr : ~last_addr_reg;
    core_page_select = req_page;  // page select follows req_page, idle cycles included
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the flash page map and protection decode
`timescale 1ns/10ps
module testbench;
  localparam int PAGE_W = 8;
  localparam logic [15:0] REG_BASE = 16'h0100;
  logic clk, arst_n, req_valid, req_write;
  logic [15:0] req_addr;
  logic [PAGE_W-1:0] req_page;
  logic [7:0] ctrl;
  logic bus_valid, bus_write, array_hit, fixed_alias, key_hit;
  logic [15:0] bus_addr;
  logic [PAGE_W-1:0] core_page_select;
  logic [14:0] array_offset;
  logic [8:0] array_row;
  logic [5:0] array_sector;
  logic [2:0] key_index;
  logic [3:0] reg_index;
  logic prot_byte_hit, sec_byte_hit, in_low_region, in_high_region;
  logic in_other_region, prot_global, prog_blocked, reg_hit;
  int errors, samples_checked, cycles;

  ////////////////////////////////////////////////////////////////////////////
  cpu_core_bus_model #(.PAGE_W(PAGE_W)) bus_u (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_page(req_page), .bus_valid(bus_valid), .bus_write(bus_write),
    .bus_addr(bus_addr), .core_page_select(core_page_select));

  flash_page_map_protect_decode #(.PAGE_W(PAGE_W), .REG_BASE(REG_BASE)) dut_u (
    .clk(clk), .arst_n(arst_n), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr),
    .core_page_select(core_page_select), .flash_protect_control(ctrl),
    .array_hit(array_hit), .array_offset(array_offset),
    .array_row(array_row), .array_sector(array_sector),
    .fixed_alias(fixed_alias), .key_hit(key_hit), .key_index(key_index),
    .prot_byte_hit(prot_byte_hit), .sec_byte_hit(sec_byte_hit),
    .in_low_region(in_low_region), .in_high_region(in_high_region),
    .in_other_region(in_other_region), .prot_global(prot_global),
    .prog_blocked(prog_blocked), .reg_hit(reg_hit), .reg_index(reg_index));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // reference decode worked out from the address map, one bus cycle
  task automatic judge(input logic v, input logic w, input logic [15:0] a,
                       input logic [7:0] pg, input logic [7:0] c);
    logic mid, hit, lo, hi, en, prot, key;
    logic [14:0] off;
    logic [15:0] hsz, lsz;
    mid = (a[15:14] == 2'b10);
    hit = v && (a >= 16'h4000) && (!mid || pg[7:1] == 7'h1f);
    off = {mid ? pg[0] : a[15], a[13:0]};
    hsz = 16'h0800 << c[4:3];
    lsz = 16'h0400 << c[1:0];
    hi = hit && ({1'b0, off} >= 16'h8000 - hsz);
    lo = hit && ({1'b0, off} < lsz);
    en = (lo && !c[2]) || (hi && !c[5]);
    prot = c[7] ? en : !en;
    key = hit && off[14:3] == 12'hfe0;
    check("array_hit", array_hit, hit);
    if (hit) begin
      check("array_offset", array_offset, off);
      check("array_row", array_row, off[14:6]);
      check("array_sector", array_sector, off[14:9]);
    end
    // the index reads zero outside the key bytes
    check("key_index", key_index, key ? off[2:0] : 3'h0);
    check("fixed_alias", fixed_alias, hit && mid);
    check("key_hit", key_hit, key);
    check("prot_byte_hit", prot_byte_hit, hit && off == 15'h7f0d);
    check("sec_byte_hit", sec_byte_hit, hit && off == 15'h7f0f);
    check("in_high_region", in_high_region, hi);
    check("in_low_region", in_low_region, lo);
    check("in_other_region", in_other_region, hit && !lo && !hi);
    check("prot_global", prot_global, !c[7] && c[5] && c[2]);
    check("prog_blocked", prog_blocked, hit && w && prot);
    check("reg_hit", reg_hit, v && a[15:4] == REG_BASE[15:4]);
    if (v && a[15:4] == REG_BASE[15:4]) begin
      check("reg_index", reg_index, a[3:0]);
    end
  endtask

  // one bus cycle: drive at the falling edge, judge after the next rise
  task automatic cycle(input logic v, input logic w, input logic [15:0] a,
                       input logic [7:0] pg, input logic [7:0] c);
    @(negedge clk);
    req_valid = v;
    req_write = w;
    req_addr = a;
    req_page = pg;
    ctrl = c;
    @(posedge clk);
    #1;
    judge(v, w, a, pg, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // window edges, paged hits and misses, fixed-page aliases
  task automatic t_windows();
    logic [15:0] adr [12] = '{16'h3fff, 16'h4000, 16'h7fff, 16'h8000,
      16'h9fff, 16'hbfff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff,
      16'h0000, 16'h2000};
    logic [7:0] pge [12] = '{8'h3e, 8'h3e, 8'h3e, 8'h3e, 8'h3e, 8'h3f,
      8'h3d, 8'h00, 8'h3f, 8'h3f, 8'h3f, 8'h3e};
    for (int i = 0; i < 12; i++) begin
      cycle(1'b1, 1'b0, adr[i], pge[i], 8'hff);
    end
  endtask

  // configuration field bytes, direct and through the paged alias
  task automatic t_config();
    for (int i = 0; i < 16; i++) begin
      cycle(1'b1, 1'b0, 16'hff00 + 16'(i), 8'h3e, 8'hff);
    end
    cycle(1'b1, 1'b0, 16'hbf0d, 8'h3f, 8'hff);
    cycle(1'b1, 1'b0, 16'hbf03, 8'h3f, 8'hff);
    cycle(1'b1, 1'b0, 16'hbf0f, 8'h3e, 8'hff);
  endtask

  // every size code at both edges of both regions, under six of the eight open and enable settings
  task automatic t_regions();
    logic [7:0] base [6] = '{8'h80, 8'h00, 8'ha4, 8'h24, 8'h84, 8'ha0};
    logic [15:0] hs, ls;
    logic [7:0] c;
    for (int n = 0; n < 4; n++) begin
      hs = 16'h0000 - (16'h0800 << n);
      ls = 16'h4000 + (16'h0400 << n);
      for (int b = 0; b < 6; b++) begin
        c = base[b] | 8'(n << 3) | 8'(n);
        cycle(1'b1, 1'b1, hs, 8'h3e, c);
        cycle(1'b1, 1'b1, hs - 16'h0001, 8'h3e, c);
        cycle(1'b1, 1'b1, ls - 16'h0001, 8'h3e, c);
        cycle(1'b1, 1'b1, ls, 8'h3e, c);
        cycle(1'b1, 1'b1, ls + 16'h4000, 8'h3e, c);
        cycle(1'b1, 1'b1, hs - 16'h4000, 8'h3f, c);
        cycle(1'b1, 1'b0, hs, 8'h3f, c);
        cycle(1'b1, 1'b1, 16'hffff, 8'h3f, c);
      end
    end
  endtask

  // register block edges, reads and writes back to back, then idle cycles
  task automatic t_regs_idle();
    for (int i = -1; i < 17; i++) begin
      cycle(1'b1, 1'(i), REG_BASE + 16'(i), 8'h3e, 8'h24);
    end
    cycle(1'b0, 1'b1, 16'hffff, 8'h3f, 8'h24);
    cycle(1'b0, 1'b0, 16'h4000, 8'h3e, 8'h00);
  endtask

  // reset in mid-run clears outputs at once, decode resumes after release
  task automatic t_reset_mid();
    cycle(1'b1, 1'b1, 16'hffff, 8'h3f, 8'h24);
    @(negedge clk);
    arst_n = 1'b0;
    #1;
    check("array_hit", array_hit, 1'b0);
    check("prot_global", prot_global, 1'b0);
    check("prog_blocked", prog_blocked, 1'b0);
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    // first edge after release decodes the cycle still on the bus
    @(posedge clk);
    #1;
    judge(1'b1, 1'b1, 16'hffff, 8'h3f, 8'h24);
    cycle(1'b1, 1'b1, 16'hff0d, 8'h3f, 8'h24);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    arst_n = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 16'hffff;
    req_page = 8'h3f;
    ctrl = 8'h24;
    repeat (20) @(posedge clk);
    #1;
    check("array_hit", array_hit, 1'b0);
    check("prog_blocked", prog_blocked, 1'b0);
    check("prot_global", prot_global, 1'b0);
    @(negedge clk);
    arst_n = 1'b1;
    @(posedge clk);
    #1;
    judge(1'b1, 1'b1, 16'hffff, 8'h3f, 8'h24);
    t_windows();
    t_config();
    t_regions();
    t_regs_idle();
    t_reset_mid();
    tally_and_finish();
  end
endmodule
